// ==== logic/ssc_pkg.sv ====
// Function
// - transmitter 3-bit select maps to spread amplitude
// - receiver 2-bit select maps to spread amplitude
// - transmitter strap high gives 0.5% default
// - receiver strap high gives 2% default
// - spread strap sampled only at power-up, power-down exit
// - transmitter spread toggle restarts link until relock
// - audio clock follows spread only when pixel-derived
// - sawtooth divider aims modulation at mid 20-40 kHz, rounding down can exceed 40 kHz
// - manual 6-bit divider at 0x03 overrides automatic
// - modulation period is coefficient times divider over rate
// - transmitter modulation coefficients per width and spread
// - receiver uses coefficient 208, maxima 15 and 30
// - transmitter sleeps at once when sleep set
// - receiver sleeps on inactivity or after 8 ms
// - controller-side device ignores sleep, reads zero
// - sleep clears protection keys, keeps configuration
// - power-down tristates, resets, resamples all straps
// - config link runs on oscillator until video enabled
// - serial link enable overrides config link, locks
package ssc_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int SLEEP_WAIT_US = 8000;
	localparam int SLEEP_WAIT_CYC = SLEEP_WAIT_US * (CLK_HZ / 1_000_000);
	localparam int MOD_F_MIN_HZ = 20_000;
	localparam int MOD_F_MAX_HZ = 40_000;
	localparam int MOD_F_MID_HZ = (MOD_F_MIN_HZ + MOD_F_MAX_HZ) / 2;
	localparam int MOD_TGT_CYC = CLK_HZ / MOD_F_MID_HZ;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_SPREAD = 8'h01;
	localparam logic [7:0] ADDR_SAWTOOTH_DIVIDER = 8'h03;
	localparam logic [7:0] ADDR_LINK = 8'h04;
	localparam logic [7:0] ADDR_EQ = 8'h05;
	localparam logic [7:0] ADDR_STATUS = 8'h06;
	localparam logic [7:0] ADDR_KEY0 = 8'h10;
	localparam int KEY_NUM = 4;
	localparam int SPR_W32_BIT = 3;
	localparam int SPR_MCLK_BIT = 4;
	localparam int SAWTOOTH_DIVIDER_MAN_BIT = 7;
	localparam int LNK_SER_BIT = 0;
	localparam int LNK_CFG_BIT = 1;
	localparam int LNK_SLEEP_BIT = 2;
	// ==========================================================
	// reset and strap values
	localparam logic [2:0] SPREAD_OFF = 3'h0;
	localparam logic [2:0] SPREAD_DEF_ON = 3'h1;
	localparam logic [3:0] EQ_STRAP_HI = 4'h4;
	localparam logic [3:0] EQ_STRAP_LO = 4'h9;
	localparam logic [7:0] SAWTOOTH_DIVIDER_RST = 8'h00;
	// ==========================================================
	// modulation coefficients and divider maxima
	localparam logic [7:0] COEF_W32_LO = 8'h68;
	localparam logic [7:0] COEF_W32_MID = 8'h98;
	localparam logic [7:0] COEF_W32_HI = 8'hCC;
	localparam logic [7:0] COEF_W24_LO = 8'h50;
	localparam logic [7:0] COEF_W24_MID = 8'h70;
	localparam logic [7:0] COEF_W24_HI = 8'h98;
	localparam logic [7:0] COEF_RX = 8'hD0;
	localparam logic [5:0] MAX_W32_P1 = 6'h28;
	localparam logic [5:0] MAX_W32_P05 = 6'h3F;
	localparam logic [5:0] MAX_W32_P3 = 6'h1B;
	localparam logic [5:0] MAX_W32_P15 = 6'h36;
	localparam logic [5:0] MAX_W32_P4 = 6'h0F;
	localparam logic [5:0] MAX_W32_P2 = 6'h1E;
	localparam logic [5:0] MAX_W24_P1 = 6'h34;
	localparam logic [5:0] MAX_W24_P05 = 6'h3F;
	localparam logic [5:0] MAX_W24_P3 = 6'h25;
	localparam logic [5:0] MAX_W24_P15 = 6'h3F;
	localparam logic [5:0] MAX_W24_P4 = 6'h15;
	localparam logic [5:0] MAX_W24_P2 = 6'h2A;
	localparam logic [5:0] MAX_RX_P4 = 6'h0F;
	localparam logic [5:0] MAX_RX_P2 = 6'h1E;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		SSC_PCT_NONE = 3'h0,
		SSC_PCT_0P5 = 3'h1,
		SSC_PCT_1 = 3'h2,
		SSC_PCT_1P5 = 3'h3,
		SSC_PCT_2 = 3'h4,
		SSC_PCT_3 = 3'h5,
		SSC_PCT_4 = 3'h6
	} ssc_pct_type;
	typedef enum logic [2:0] {
		SSC_LS_OFF = 3'b000,
		SSC_LS_CFG = 3'b001,
		SSC_LS_LOCK = 3'b010,
		SSC_LS_UP = 3'b011,
		SSC_LS_SLEEP = 3'b100
	} ssc_link_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ssc_req_type;
	typedef struct packed {
		logic spread;
		logic rate;
		logic autostart_n;
		logic eq;
	} ssc_strap_type;
endpackage

// ==== logic/ssc_sawtooth.sv ====
`timescale 1ns/1ns
module ssc_sawtooth #(
	parameter int PW = 14
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// control
	input wire logic run_i,
	input wire logic [PW-1:0] period_i,
	// ramp
	output logic tick_o,
	output logic [PW-1:0] phase_o
);
	if (PW < 2) begin : g_bad_pw
		$error("ssc_sawtooth: PW too small");
	end
	logic [PW-1:0] cnt_reg, cnt_next;
	logic tick_reg, tick_next;
	always_comb begin
		cnt_next = cnt_reg + 1'b1;
		tick_next = 1'b0;
		if (!run_i || period_i == '0) begin
			cnt_next = '0;
		end else if (cnt_reg >= period_i - 1'b1) begin
			cnt_next = '0;
			tick_next = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end
	assign tick_o = tick_reg;
	assign phase_o = cnt_reg;
endmodule

// ==== logic/ssc_ctrl.sv ====
`timescale 1ns/1ns
module ssc_ctrl import ssc_pkg::*; #(
	parameter bit IS_RX = 1'b0,
	parameter int SLEEP_CYC = SLEEP_WAIT_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// pins and straps
	input wire logic power_down_n_i,
	input wire logic spread_default_strap_i,
	input wire logic rate_select_strap_i,
	input wire logic autostart_strap_n_i,
	input wire logic equalizer_default_strap_i,
	input wire logic controller_attached_i,
	// link status
	input wire logic relock_i,
	input wire logic link_activity_i,
	// register access
	input wire ssc_req_type req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// spread control
	output ssc_pct_type spread_o,
	output logic spread_on_o,
	output logic audio_clk_spread_o,
	output logic [5:0] divider_o,
	output logic mod_tick_o,
	// link control
	output ssc_link_type link_state_o,
	output logic link_available_o,
	output logic osc_select_o,
	output logic sleep_o,
	output logic out_en_o,
	output logic [3:0] eq_level_o
);
	if (SLEEP_CYC < 1 || SLEEP_CYC > 16777215) begin : g_bad_sleep_cyc
		$error("ssc_ctrl: bad SLEEP_CYC");
	end
	// ==========================================================
	// input synchronisers
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] sync1_reg, sync2_reg;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {link_activity_i, relock_i, controller_attached_i, equalizer_default_strap_i,
				autostart_strap_n_i, rate_select_strap_i, spread_default_strap_i, power_down_n_i};
			sync2_reg <= sync1_reg;
		end
	end
	logic pd_n, ctl_side, relock, activity;
	assign pd_n = sync2_reg[0];
	assign ctl_side = sync2_reg[5];
	assign relock = sync2_reg[6];
	assign activity = sync2_reg[7];
	// ==========================================================
	// decode helpers
	function automatic ssc_pct_type decode_pct(input logic [2:0] sel);
		ssc_pct_type p;
		p = SSC_PCT_NONE;
		if (IS_RX) begin
			case (sel[1:0])
				2'b01: p = SSC_PCT_2;
				2'b11: p = SSC_PCT_4;
				default: p = SSC_PCT_NONE;
			endcase
		end else begin
			case (sel)
				3'b001: p = SSC_PCT_0P5;
				3'b010: p = SSC_PCT_1P5;
				3'b011: p = SSC_PCT_2;
				3'b101: p = SSC_PCT_1;
				3'b110: p = SSC_PCT_3;
				3'b111: p = SSC_PCT_4;
				default: p = SSC_PCT_NONE;
			endcase
		end
		return p;
	endfunction
	function automatic logic [7:0] coef_of(input ssc_pct_type p, input logic w32);
		logic [7:0] c;
		c = IS_RX ? COEF_RX : (w32 ? COEF_W32_LO : COEF_W24_LO);
		if (!IS_RX) begin
			case (p)
				SSC_PCT_1P5, SSC_PCT_3: c = w32 ? COEF_W32_MID : COEF_W24_MID;
				SSC_PCT_2, SSC_PCT_4: c = w32 ? COEF_W32_HI : COEF_W24_HI;
				default: c = w32 ? COEF_W32_LO : COEF_W24_LO;
			endcase
		end
		return c;
	endfunction
	function automatic logic [5:0] max_of(input ssc_pct_type p, input logic w32);
		logic [5:0] m;
		m = MAX_W24_P05;
		case (p)
			SSC_PCT_1: m = w32 ? MAX_W32_P1 : MAX_W24_P1;
			SSC_PCT_0P5: m = w32 ? MAX_W32_P05 : MAX_W24_P05;
			SSC_PCT_3: m = w32 ? MAX_W32_P3 : MAX_W24_P3;
			SSC_PCT_1P5: m = w32 ? MAX_W32_P15 : MAX_W24_P15;
			SSC_PCT_4: m = IS_RX ? MAX_RX_P4 : (w32 ? MAX_W32_P4 : MAX_W24_P4);
			SSC_PCT_2: m = IS_RX ? MAX_RX_P2 : (w32 ? MAX_W32_P2 : MAX_W24_P2);
			default: m = MAX_W24_P05;
		endcase
		return m;
	endfunction
	// ==========================================================
	// configuration registers
	logic pd_prev_reg;
	ssc_strap_type strap_reg, strap_next;
	logic [7:0] spread_cfg_reg, spread_cfg_next;
	logic [7:0] spread_divider_cfg_reg, spread_divider_cfg_next;
	logic ser_en_reg, ser_en_next;
	logic cfg_en_reg, cfg_en_next;
	logic sleep_bit_reg, sleep_bit_next;
	logic [3:0] eq_reg, eq_next;
	logic [KEY_NUM-1:0][7:0] key_reg, key_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic strap_load, sleep_enter;
	ssc_link_type state_reg, state_next;
	logic relock_lost_reg, relock_lost_next;
	assign strap_load = pd_n && !pd_prev_reg;
	always_comb begin
		strap_next = strap_reg;
		spread_cfg_next = spread_cfg_reg;
		spread_divider_cfg_next = spread_divider_cfg_reg;
		ser_en_next = ser_en_reg;
		cfg_en_next = cfg_en_reg;
		sleep_bit_next = sleep_bit_reg;
		eq_next = eq_reg;
		key_next = key_reg;
		rdata_next = 8'h00;
		rvalid_next = 1'b0;
		if (!pd_n) begin
			// power-down holds every configuration and key register at its reset value
			strap_next = '0;
			spread_cfg_next = {5'h00, SPREAD_OFF};
			spread_divider_cfg_next = SAWTOOTH_DIVIDER_RST;
			ser_en_next = 1'b0;
			cfg_en_next = 1'b0;
			sleep_bit_next = 1'b0;
			eq_next = EQ_STRAP_LO;
			key_next = '0;
		end else if (strap_load) begin
			// straps are caught only here, later pin changes are ignored
			strap_next = {sync2_reg[1], sync2_reg[2], sync2_reg[3], sync2_reg[4]};
			spread_cfg_next[2:0] = sync2_reg[1] ? SPREAD_DEF_ON : SPREAD_OFF;
			ser_en_next = !sync2_reg[3];
			eq_next = sync2_reg[4] ? EQ_STRAP_HI : EQ_STRAP_LO;
		end else begin
			if (req_i.wr) begin
				case (req_i.addr)
					ADDR_SPREAD: spread_cfg_next = {3'h0, req_i.wdata[4:0]};
					ADDR_SAWTOOTH_DIVIDER: spread_divider_cfg_next = req_i.wdata;
					ADDR_LINK: begin
						ser_en_next = req_i.wdata[LNK_SER_BIT];
						cfg_en_next = req_i.wdata[LNK_CFG_BIT];
						sleep_bit_next = req_i.wdata[LNK_SLEEP_BIT] && !ctl_side;
					end
					ADDR_EQ: eq_next = req_i.wdata[3:0];
					default: begin
						for (int k = 0; k < KEY_NUM; k++) begin
							if (req_i.addr == ADDR_KEY0 + 8'(k)) begin
								key_next[k] = req_i.wdata;
							end
						end
					end
				endcase
			end
			if (ctl_side) begin
				sleep_bit_next = 1'b0;
			end
			if (state_reg == SSC_LS_SLEEP && relock && relock_lost_reg) begin
				sleep_bit_next = 1'b0;
			end
			if (sleep_enter) begin
				key_next = '0;
			end
		end
		if (req_i.rd) begin
			rvalid_next = 1'b1;
			case (req_i.addr)
				ADDR_SPREAD: rdata_next = spread_cfg_reg;
				ADDR_SAWTOOTH_DIVIDER: rdata_next = spread_divider_cfg_reg;
				ADDR_LINK: rdata_next = {5'h00, sleep_bit_reg, cfg_en_reg, ser_en_reg};
				ADDR_EQ: rdata_next = {4'h0, eq_reg};
				ADDR_STATUS: rdata_next = {3'h0, strap_reg.rate, spread_on_o, state_reg};
				default: begin
					for (int k = 0; k < KEY_NUM; k++) begin
						if (req_i.addr == ADDR_KEY0 + 8'(k)) begin
							rdata_next = key_reg[k];
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pd_prev_reg <= 1'b0;
			strap_reg <= '0;
			spread_cfg_reg <= {5'h00, SPREAD_OFF};
			spread_divider_cfg_reg <= SAWTOOTH_DIVIDER_RST;
			ser_en_reg <= 1'b0;
			cfg_en_reg <= 1'b0;
			sleep_bit_reg <= 1'b0;
			eq_reg <= EQ_STRAP_LO;
			key_reg <= '0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			pd_prev_reg <= pd_n;
			strap_reg <= strap_next;
			spread_cfg_reg <= spread_cfg_next;
			spread_divider_cfg_reg <= spread_divider_cfg_next;
			ser_en_reg <= ser_en_next;
			cfg_en_reg <= cfg_en_next;
			sleep_bit_reg <= sleep_bit_next;
			eq_reg <= eq_next;
			key_reg <= key_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end
	// ==========================================================
	// spread decode and sawtooth divider
	ssc_pct_type pct;
	logic w32;
	logic [7:0] coef;
	logic [5:0] max_div, auto_div, div_sel;
	logic [13:0] period;
	logic [15:0] auto_raw;
	ssc_pct_type spread_reg, spread_next;
	logic spread_on_reg, spread_on_next;
	logic audio_reg, audio_next;
	logic [5:0] div_reg, div_next;
	assign pct = decode_pct(spread_cfg_reg[2:0]);
	assign w32 = spread_cfg_reg[SPR_W32_BIT];
	assign coef = coef_of(pct, w32);
	assign max_div = max_of(pct, w32);
	// the automatic value aims at the middle of the allowed band
	assign auto_raw = 16'((MOD_TGT_CYC * (strap_reg.rate ? 2 : 1)) / int'(coef));
	always_comb begin
		auto_div = max_div;
		if (auto_raw == 16'h0000) begin
			auto_div = 6'h01;
		end else if (auto_raw < {10'h000, max_div}) begin
			auto_div = auto_raw[5:0];
		end
		div_sel = spread_divider_cfg_reg[SAWTOOTH_DIVIDER_MAN_BIT] ? spread_divider_cfg_reg[5:0] : auto_div;
		spread_next = pct;
		spread_on_next = (pct != SSC_PCT_NONE) && pd_n;
		div_next = div_sel;
		// pixel-derived audio clock is the only audio path spread may touch
		audio_next = !IS_RX && spread_on_next && !spread_cfg_reg[SPR_MCLK_BIT];
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spread_reg <= SSC_PCT_NONE;
			spread_on_reg <= 1'b0;
			audio_reg <= 1'b0;
			div_reg <= 6'h01;
		end else begin
			spread_reg <= spread_next;
			spread_on_reg <= spread_on_next;
			audio_reg <= audio_next;
			div_reg <= div_next;
		end
	end
	// period of one ramp is coefficient times divider, halved by the rate strap
	assign period = 14'(({6'h00, coef} * {8'h00, div_reg}) >> strap_reg.rate);
	ssc_sawtooth #(.PW(14)) u_saw (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.run_i(spread_on_reg && state_reg == SSC_LS_UP),
		.period_i(period),
		.tick_o(mod_tick_o),
		.phase_o()
	);
	// ==========================================================
	// link and sleep sequencing
	logic [23:0] sleep_cnt_reg, sleep_cnt_next;
	logic sleep_go, restart;
	logic avail_reg, avail_next;
	logic osc_reg, osc_next;
	logic out_en_reg, out_en_next;
	logic sleep_reg, sleep_next;
	// turning transmitter spread on or off drops the lock
	assign restart = !IS_RX && (spread_on_next != spread_on_reg);
	always_comb begin
		sleep_cnt_next = 24'h000000;
		sleep_go = 1'b0;
		if (sleep_bit_reg && state_reg != SSC_LS_SLEEP) begin
			if (!IS_RX) begin
				sleep_go = 1'b1;
			end else begin
				sleep_cnt_next = sleep_cnt_reg + 24'h000001;
				sleep_go = !activity || (sleep_cnt_reg >= 24'(SLEEP_CYC - 1));
			end
		end
		sleep_enter = sleep_go;
		state_next = state_reg;
		// a lock seen before the far end dropped it is stale and must not bring the link up
		relock_lost_next = (state_reg == SSC_LS_LOCK || state_reg == SSC_LS_SLEEP) && (relock_lost_reg || !relock);
		case (state_reg)
			SSC_LS_SLEEP: begin
				if (!sleep_bit_reg) begin
					state_next = ser_en_reg ? SSC_LS_LOCK : SSC_LS_OFF;
				end
			end
			SSC_LS_OFF, SSC_LS_CFG: begin
				if (ser_en_reg) begin
					state_next = SSC_LS_LOCK;
				end else if (cfg_en_reg) begin
					state_next = SSC_LS_CFG;
				end else begin
					state_next = SSC_LS_OFF;
				end
			end
			SSC_LS_LOCK: begin
				if (!ser_en_reg) begin
					state_next = SSC_LS_OFF;
				end else if (relock && relock_lost_reg && !restart) begin
					state_next = SSC_LS_UP;
				end
			end
			SSC_LS_UP: begin
				if (!ser_en_reg) begin
					state_next = SSC_LS_OFF;
				end else if (restart || !relock) begin
					state_next = SSC_LS_LOCK;
				end
			end
			default: state_next = SSC_LS_OFF;
		endcase
		if (sleep_go) begin
			state_next = SSC_LS_SLEEP;
		end
		if (!pd_n) begin
			state_next = SSC_LS_OFF;
		end
		avail_next = state_next == SSC_LS_UP;
		osc_next = state_next == SSC_LS_CFG;
		out_en_next = pd_n && state_next != SSC_LS_SLEEP;
		sleep_next = state_next == SSC_LS_SLEEP;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= SSC_LS_OFF;
			sleep_cnt_reg <= 24'h000000;
			avail_reg <= 1'b0;
			osc_reg <= 1'b0;
			out_en_reg <= 1'b0;
			sleep_reg <= 1'b0;
			relock_lost_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sleep_cnt_reg <= sleep_cnt_next;
			avail_reg <= avail_next;
			osc_reg <= osc_next;
			out_en_reg <= out_en_next;
			sleep_reg <= sleep_next;
			relock_lost_reg <= relock_lost_next;
		end
	end
	// ==========================================================
	// outputs
	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign spread_o = spread_reg;
	assign spread_on_o = spread_on_reg;
	assign audio_clk_spread_o = audio_reg;
	assign divider_o = div_reg;
	assign link_state_o = state_reg;
	assign link_available_o = avail_reg;
	assign osc_select_o = osc_reg;
	assign sleep_o = sleep_reg;
	assign out_en_o = out_en_reg;
	assign eq_level_o = eq_reg;
endmodule

// ==== dv/ssc_ctrl_sva.sv ====
`timescale 1ns/1ns
// ==========================================
// port checks of the spread and link control
module ssc_ctrl_chk import ssc_pkg::*; #(
	parameter bit IS_RX = 1'b0,
	parameter int SLEEP_CYC = 20
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// inputs watched
	input wire logic power_down_n_i,
	input wire ssc_req_type req_i,
	// outputs watched
	input wire logic rvalid_o,
	input wire ssc_pct_type spread_o,
	input wire logic spread_on_o,
	input wire logic audio_clk_spread_o,
	input wire logic mod_tick_o,
	input wire ssc_link_type link_state_o,
	input wire logic link_available_o,
	input wire logic osc_select_o,
	input wire logic sleep_o,
	input wire logic out_en_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_read_answer_pulse: assert property (rvalid_o |-> $past(req_i.rd))
		else $error("read answer without a read request");
	a_spread_flag_match: assert property (spread_on_o |-> spread_o != SSC_PCT_NONE || $past(spread_o) != SSC_PCT_NONE)
		else $error("spread active while decode says none");
	// pin passes two sync flops, so four low samples are needed before the outputs must be off
	a_pd_outputs_off: assert property (!power_down_n_i [*4] |-> !out_en_o)
		else $error("outputs enabled in power-down");
	a_sleep_outputs_off: assert property (sleep_o [*2] |-> !out_en_o && !link_available_o)
		else $error("outputs enabled while asleep");
	a_link_up_flag: assert property (link_available_o |-> link_state_o == SSC_LS_UP || $past(link_state_o) == SSC_LS_UP)
		else $error("link available outside up state");
	a_osc_cfg_flag: assert property (osc_select_o |-> link_state_o == SSC_LS_CFG || $past(link_state_o) == SSC_LS_CFG)
		else $error("oscillator selected outside config link");
	a_spread_restart: assert property (!IS_RX && $changed(spread_on_o) |-> ##[0:2] !link_available_o)
		else $error("spread toggle did not restart the link");
	a_audio_follow: assert property (audio_clk_spread_o |-> spread_on_o || $past(spread_on_o))
		else $error("audio clock spread without spread");
	a_tick_needs_spread: assert property (mod_tick_o |-> spread_on_o || $past(spread_on_o))
		else $error("modulation tick without spread");
	c_read: cover property (rvalid_o);
	c_sleep: cover property (sleep_o);
	c_tick: cover property (mod_tick_o);
endmodule
bind ssc_ctrl ssc_ctrl_chk #(.IS_RX(IS_RX), .SLEEP_CYC(SLEEP_CYC)) i_ssc_ctrl_chk (.*);

// ==== dv/ssc_far_end.sv ====
`timescale 1ns/1ns
// ==========================================
// far end of the serial link: locks some cycles after our carrier settles
module ssc_far_end import ssc_pkg::*; #(
	parameter int LOCK_CYC = 6
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// our side
	input wire ssc_link_type link_state_i,
	// answers
	output logic relock_o,
	output logic link_activity_o
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	ssc_link_type prev_reg;
	assign link_activity_o = link_state_i inside {SSC_LS_CFG, SSC_LS_LOCK, SSC_LS_UP};
	assign relock_o = cnt_reg >= 8'(LOCK_CYC);
	always_comb begin
		cnt_next = cnt_reg;
		// entering lock from any other state loses lock, the receiver must find the data again
		if (!link_activity_o || (link_state_i == SSC_LS_LOCK && prev_reg != SSC_LS_LOCK)) begin
			cnt_next = 8'h00;
		end else if (cnt_reg != 8'hFF) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 8'h00;
			prev_reg <= SSC_LS_OFF;
		end else begin
			cnt_reg <= cnt_next;
			prev_reg <= link_state_i;
		end
	end
endmodule

// ==== dv/test_spread_spectrum_power_mode_ctrl.sv ====
`timescale 1ns/1ns
module test_spread_spectrum_power_mode_ctrl import ssc_pkg::*;;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic power_down_n_i = 1'b1;
	logic spread_default_strap_i = 1'b1;
	logic rate_select_strap_i = 1'b0;
	logic autostart_strap_n_i = 1'b1;
	logic equalizer_default_strap_i = 1'b1;
	logic controller_attached_i = 1'b0;
	ssc_req_type req_i = '0;
	logic relock_i, link_activity_i, rvalid_o, spread_on_o, audio_clk_spread_o, mod_tick_o;
	logic link_available_o, osc_select_o, sleep_o, out_en_o;
	logic [7:0] rdata_o;
	logic [5:0] divider_o;
	logic [3:0] eq_level_o;
	ssc_pct_type spread_o;
	ssc_link_type link_state_o;
	ssc_req_type rx_req = '0;
	logic rx_act = 1'b1;
	logic rx_sleep;
	ssc_pct_type rx_spread;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	ssc_ctrl #(.IS_RX(1'b0), .SLEEP_CYC(20)) i_ssc_ctrl (.*);
	ssc_far_end #(.LOCK_CYC(6)) i_ssc_far_end (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.link_state_i(link_state_o), .relock_o(relock_i), .link_activity_o(link_activity_i));
	ssc_ctrl #(.IS_RX(1'b1), .SLEEP_CYC(20)) i_ssc_ctrl_rx (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.power_down_n_i(power_down_n_i), .spread_default_strap_i(spread_default_strap_i),
		.rate_select_strap_i(rate_select_strap_i), .autostart_strap_n_i(autostart_strap_n_i),
		.equalizer_default_strap_i(equalizer_default_strap_i), .controller_attached_i(controller_attached_i),
		.relock_i(relock_i), .link_activity_i(rx_act), .req_i(rx_req), .rdata_o(), .rvalid_o(),
		.spread_o(rx_spread), .spread_on_o(), .audio_clk_spread_o(), .divider_o(), .mod_tick_o(),
		.link_state_o(), .link_available_o(), .osc_select_o(), .sleep_o(rx_sleep), .out_en_o(), .eq_level_o());
	always #50 clk_sys_i = ~clk_sys_i;
	// ==========================================
	// shared tasks
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i) req_i <= '0;
	endtask
	task automatic wr_rx(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) rx_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i) rx_req <= '0;
	endtask
	task automatic wait_on(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys_i) req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i) req_i <= '0;
		@(negedge clk_sys_i);
		wait_on(rvalid_o, 1'b1, 3);
		chk({7'h0, rvalid_o}, 8'h01, "read answer");
		chk(rdata_o, exp, what);
	endtask
	// ==========================================
	// scenarios
	task automatic t_defaults;
		@(negedge clk_sys_i);
		chk({5'h0, spread_o}, {5'h0, SSC_PCT_0P5}, "strap spread");
		chk({4'h0, eq_level_o}, {4'h0, EQ_STRAP_HI}, "strap eq");
		chk({5'h0, link_state_o}, {5'h0, SSC_LS_OFF}, "idle link");
		rd(ADDR_SPREAD, {5'h0, SPREAD_DEF_ON}, "spread reg");
		rd(ADDR_SAWTOOTH_DIVIDER, SAWTOOTH_DIVIDER_RST, "divider reg");
		rd(8'h7F, 8'h00, "unmapped");
		$display("test defaults done");
	endtask
	task automatic t_power_down;
		@(posedge clk_sys_i) spread_default_strap_i <= 1'b0;
		equalizer_default_strap_i <= 1'b0;
		wr(ADDR_SAWTOOTH_DIVIDER, 8'h85);
		repeat (10) @(negedge clk_sys_i);
		chk({5'h0, spread_o}, {5'h0, SSC_PCT_0P5}, "strap ignored");
		@(posedge clk_sys_i) power_down_n_i <= 1'b0;
		repeat (5) @(negedge clk_sys_i);
		chk({7'h0, out_en_o}, 8'h00, "outputs off");
		// straps go high again so that only a relatch can undo the power-down reset values
		@(posedge clk_sys_i) power_down_n_i <= 1'b1;
		spread_default_strap_i <= 1'b1;
		equalizer_default_strap_i <= 1'b1;
		repeat (6) @(negedge clk_sys_i);
		chk({5'h0, spread_o}, {5'h0, SSC_PCT_0P5}, "strap relatched");
		chk({4'h0, eq_level_o}, {4'h0, EQ_STRAP_HI}, "eq relatched");
		rd(ADDR_SAWTOOTH_DIVIDER, SAWTOOTH_DIVIDER_RST, "divider cleared");
		$display("test power down done");
	endtask
	task automatic t_rx;
		chk({5'h0, rx_spread}, {5'h0, SSC_PCT_2}, "rx strap spread");
		wr_rx(ADDR_SPREAD, 8'h03);
		repeat (2) @(negedge clk_sys_i);
		chk({5'h0, rx_spread}, {5'h0, SSC_PCT_4}, "rx decode");
		wr_rx(ADDR_SPREAD, 8'h02);
		repeat (2) @(negedge clk_sys_i);
		chk({5'h0, rx_spread}, {5'h0, SSC_PCT_NONE}, "rx decode off");
		wr_rx(ADDR_LINK, 8'h04);
		repeat (18) @(negedge clk_sys_i);
		chk({7'h0, rx_sleep}, 8'h00, "rx awake before wait");
		repeat (3) @(negedge clk_sys_i);
		chk({7'h0, rx_sleep}, 8'h01, "rx sleeps after wait");
		wr_rx(ADDR_LINK, 8'h00);
		@(posedge clk_sys_i) rx_act <= 1'b0;
		@(negedge clk_sys_i);
		chk({7'h0, rx_sleep}, 8'h00, "rx woken");
		wr_rx(ADDR_LINK, 8'h04);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h0, rx_sleep}, 8'h01, "rx sleeps on idle");
		$display("test receiver done");
	endtask
	task automatic t_decode;
		ssc_pct_type exp [8] = '{SSC_PCT_NONE, SSC_PCT_0P5, SSC_PCT_1P5, SSC_PCT_2,
			SSC_PCT_NONE, SSC_PCT_1, SSC_PCT_3, SSC_PCT_4};
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_SPREAD, 8'(i));
			repeat (2) @(negedge clk_sys_i);
			chk({5'h0, spread_o}, {5'h0, exp[i]}, "decode");
		end
		$display("test decode done");
	endtask
	task automatic t_link;
		int n;
		wr(ADDR_SPREAD, 8'h00);
		wr(ADDR_LINK, 8'h02);
		wait_on(osc_select_o, 1'b1, 5);
		chk({7'h0, osc_select_o}, 8'h01, "config link on");
		wr(ADDR_LINK, 8'h03);
		wait_on(osc_select_o, 1'b0, 5);
		chk({7'h0, osc_select_o}, 8'h00, "video overrides");
		wait_on(link_available_o, 1'b1, 30);
		chk({7'h0, link_available_o}, 8'h01, "video locked");
		wr(ADDR_SAWTOOTH_DIVIDER, 8'h83);
		wr(ADDR_SPREAD, 8'h01);
		wait_on(link_available_o, 1'b0, 3);
		chk({7'h0, link_available_o}, 8'h00, "restart on spread");
		wait_on(link_available_o, 1'b1, 30);
		chk({7'h0, link_available_o}, 8'h01, "relocked");
		chk({2'h0, divider_o}, 8'h03, "manual divider");
		chk({7'h0, audio_clk_spread_o}, 8'h01, "audio follows");
		wait_on(mod_tick_o, 1'b1, 600);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (mod_tick_o !== 1'b1 && n < 600);
		// 24-bit mode, half percent, rate strap low: period is coefficient times divider
		chk(8'(n), 8'(int'(COEF_W24_LO) * 3), "modulation period");
		wr(ADDR_SPREAD, 8'h11);
		repeat (2) @(negedge clk_sys_i);
		chk({7'h0, audio_clk_spread_o}, 8'h00, "audio source apart");
		$display("test link done");
	endtask
	task automatic t_sleep;
		wr(ADDR_KEY0, 8'hA5);
		rd(ADDR_KEY0, 8'hA5, "key written");
		wr(ADDR_LINK, 8'h05);
		wait_on(sleep_o, 1'b1, 3);
		chk({7'h0, sleep_o}, 8'h01, "sleep at once");
		@(negedge clk_sys_i);
		chk({7'h0, out_en_o}, 8'h00, "asleep outputs off");
		rd(ADDR_KEY0, 8'h00, "key cleared");
		rd(ADDR_SPREAD, 8'h11, "config kept");
		wr(ADDR_LINK, 8'h00);
		wait_on(sleep_o, 1'b0, 4);
		@(posedge clk_sys_i) controller_attached_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		wr(ADDR_LINK, 8'h04);
		repeat (3) @(negedge clk_sys_i);
		chk({7'h0, sleep_o}, 8'h00, "attached never sleeps");
		rd(ADDR_LINK, 8'h00, "sleep bit reads zero");
		$display("test sleep done");
	endtask
	// ==========================================
	// run and watchdog
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		t_defaults();
		t_power_down();
		t_rx();
		t_decode();
		t_link();
		t_sleep();
		test_done();
	end
endmodule
